/* design/bmm_params.svh */
// Address map, reset values and vectors of the banked memory map block
`ifndef BMM_PARAMS_SVH
`define BMM_PARAMS_SVH

`define BMM_PC_W           13
`define BMM_PROG_AW        11
`define BMM_RESET_VECTOR   13'h0000
`define BMM_IRQ_VECTOR     13'h0004
`define BMM_PC_STEP        13'h0001

`define BMM_OFF_INDIRECT   7'h00
`define BMM_OFF_STATUS     7'h03
`define BMM_OFF_POINTER    7'h04
`define BMM_ADDR_LATCH     9'h005
`define BMM_ADDR_DIRECTION 9'h085
`define BMM_ADDR_ANALOG    9'h09f

`define BMM_BANK_HI_BIT    6
`define BMM_BANK_LO_BIT    5
`define BMM_IRP_BIT        7

`define BMM_GP_LOW_OFF     7'h20
`define BMM_GP_ODD_TOP     7'h3f
`define BMM_GP_ODD_BASE    7'h40
`define BMM_RAM_DEPTH      128

`define BMM_STATUS_RESET   8'h00
`define BMM_POINTER_RESET  8'h00
`define BMM_LATCH_RESET    5'h00
`define BMM_DIR_RESET      6'h3f
`define BMM_CFG_RESET      3'h0
`define BMM_KEEP_BIT       5
`define BMM_OPEN_DRAIN_BIT 4

`endif

/* design/bmm_pkg.sv */
// Types shared by the banked memory map block
package bmm_pkg;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } bmm_data_req_s;

   typedef struct packed {
      logic [12:0] pc;
      logic [7:0]  status;
      logic [7:0]  pointer;
      logic [5:0]  latch;
      logic [5:0]  dir;
      logic [2:0]  cfg;
      logic [7:0]  rdata;
      logic        ram_sel;
   } bmm_state_s;

endpackage

/* design/bmm_ram.sv */
// General purpose static RAM with registered read data
`timescale 1ns/1ps
module bmm_ram
   import bmm_pkg::*;
#(
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   input  wire logic          clock,
   input  wire logic          wr_en,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);

   logic [7:0] mem [DEPTH];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[addr] <= wdata;
      end
      if (rd_en) begin
         rdata <= mem[addr];
      end
   end

endmodule // bmm_ram

/* design/bmm_top.sv */
// Program counter, banked data map and port A registers
// Operation
// - Thirteen bit program counter, 8K word space
// - Only 0000h-07FFh present, higher addresses wrap
// - Reset starts 0000h, interrupt loads 0004h
// - Direct bank chosen by status bits 6 and 5, indirect bank by status bit 7 and pointer bit 7
// - Banks 128 bytes, special registers below RAM
// - Status register reachable in every bank
// - Direct or indirect access through pointer register
// - Fetch and data access proceed together
// - Latch bit5 kept on warm reset, rest cleared
// - Direction register all ones on any reset
// - Three bit config field cleared on reset
// - Unimplemented port register bits read zero
`timescale 1ns/1ps
`include "bmm_params.svh"
module bmm_top
   import bmm_pkg::*;
#(
   parameter int RAM_DEPTH = `BMM_RAM_DEPTH
) (
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic                    reset_is_por,
   input  wire logic                    pc_inc,
   input  wire logic                    pc_load,
   input  wire logic [`BMM_PC_W-1:0]    pc_load_value,
   input  wire logic                    irq_accept,
   output logic      [`BMM_PC_W-1:0]    prog_counter,
   output logic      [`BMM_PROG_AW-1:0] fetch_addr,
   input  wire bmm_data_req_s           data_req,
   output logic      [7:0]              data_rdata,
   output logic      [7:0]              status_out,
   input  wire logic [5:0]              pin_in,
   output logic      [5:0]              pin_out,
   output logic      [5:0]              pin_oe,
   output logic      [2:0]              port_config_field
);

   bmm_state_s st;
   bmm_state_s next_st;
   logic [8:0] eff_addr;
   logic [1:0] bank;
   logic [6:0] off;
   logic       ram_hit;
   logic [6:0] ram_addr;
   logic [7:0] ram_rdata;

   always_comb begin
      if (data_req.addr == `BMM_OFF_INDIRECT) begin
         eff_addr = {st.status[`BMM_IRP_BIT], st.pointer};
      end else begin
         eff_addr = {st.status[`BMM_BANK_HI_BIT],
                     st.status[`BMM_BANK_LO_BIT], data_req.addr};
      end
      bank = eff_addr[8:7];
      off  = eff_addr[6:0];
      ram_hit = (off >= `BMM_GP_LOW_OFF) &&
                (!bank[0] || (off <= `BMM_GP_ODD_TOP));
      if (bank[0]) begin
         ram_addr = off + `BMM_GP_ODD_BASE;
      end else begin
         ram_addr = off - `BMM_GP_LOW_OFF;
      end
   end

   always_comb begin
      next_st = st;
      next_st.ram_sel = 1'b0;
      if (irq_accept) begin
         next_st.pc = `BMM_IRQ_VECTOR;
      end else if (pc_load) begin
         next_st.pc = pc_load_value;
      end else if (pc_inc) begin
         next_st.pc = st.pc + `BMM_PC_STEP;
      end
      if (data_req.wr) begin
         if (off == `BMM_OFF_STATUS) begin
            next_st.status = data_req.wdata;
         end
         if (off == `BMM_OFF_POINTER) begin
            next_st.pointer = data_req.wdata;
         end
         unique case (eff_addr)
            `BMM_ADDR_LATCH:     next_st.latch = data_req.wdata[5:0];
            `BMM_ADDR_DIRECTION: next_st.dir   = data_req.wdata[5:0];
            `BMM_ADDR_ANALOG:    next_st.cfg   = data_req.wdata[2:0];
            default: ;
         endcase
      end
      if (data_req.rd) begin
         next_st.ram_sel = ram_hit;
         next_st.rdata   = 8'h00;
         if (off == `BMM_OFF_STATUS) begin
            next_st.rdata = st.status;
         end
         if (off == `BMM_OFF_POINTER) begin
            next_st.rdata = st.pointer;
         end
         unique case (eff_addr)
            `BMM_ADDR_LATCH:     next_st.rdata = {2'h0, pin_in};
            `BMM_ADDR_DIRECTION: next_st.rdata = {2'h0, st.dir};
            `BMM_ADDR_ANALOG:    next_st.rdata = {5'h00, st.cfg};
            default: ;
         endcase
      end
      if (rst) begin
         next_st.pc      = `BMM_RESET_VECTOR;
         next_st.status  = `BMM_STATUS_RESET;
         next_st.pointer = `BMM_POINTER_RESET;
         // bit five kept on warm reset
         next_st.latch = {reset_is_por ? 1'b0 : st.latch[`BMM_KEEP_BIT],
                          `BMM_LATCH_RESET};
         next_st.dir     = `BMM_DIR_RESET;
         next_st.cfg     = `BMM_CFG_RESET;
         next_st.rdata   = 8'h00;
         next_st.ram_sel = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      st <= next_st;
   end

   bmm_ram #(
      .DEPTH (RAM_DEPTH),
      .AW    (7)
   ) u_ram (
      .clock (clock),
      .wr_en (data_req.wr && ram_hit && !rst),
      .rd_en (data_req.rd && ram_hit),
      .addr  (ram_addr),
      .wdata (data_req.wdata),
      .rdata (ram_rdata)
   );

   assign prog_counter      = st.pc;
   assign fetch_addr        = st.pc[`BMM_PROG_AW-1:0];
   assign data_rdata        = st.ram_sel ? ram_rdata : st.rdata;
   assign status_out        = st.status;
   assign port_config_field = st.cfg;

   always_comb begin
      pin_out = st.latch;
      pin_oe  = ~st.dir;
      pin_out[`BMM_OPEN_DRAIN_BIT] = 1'b0;
      pin_oe[`BMM_OPEN_DRAIN_BIT]  = ~st.dir[`BMM_OPEN_DRAIN_BIT] &
                                     ~st.latch[`BMM_OPEN_DRAIN_BIT];
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_reset_vector: assert property (
      @(posedge clock) disable iff (1'b0)
      rst |=> (prog_counter == `BMM_RESET_VECTOR) && (pin_oe == 6'h00))
      else $error("pc or drivers wrong after reset");

   chk_irq_vector: assert property (
      irq_accept |=> fetch_addr == 11'h004)
      else $error("interrupt did not load vector");

   chk_fetch_wrap: assert property (
      pc_load && !irq_accept |=>
      {2'b00, fetch_addr} == ($past(pc_load_value) & 13'h07ff))
      else $error("fetch address does not wrap");

   chk_fetch_parallel: assert property (
      pc_inc && !pc_load && !irq_accept && data_req.wr |=>
      prog_counter == $past(prog_counter) + 13'h0001)
      else $error("fetch stalled by data access");

   chk_banked_write: assert property (
      data_req.wr && data_req.addr == 7'h05 &&
      status_out[6:5] == 2'b01 |=>
      pin_oe[3:0] == ~4'($past(data_req.wdata)))
      else $error("bank one write missed direction");

   chk_status_mirror: assert property (
      data_req.wr && data_req.addr == 7'h03 |=>
      status_out == $past(data_req.wdata))
      else $error("status not mirrored");

   chk_indirect_read: assert property (
      data_req.rd && data_req.addr == 7'h00 &&
      st.pointer == 8'h9f && !status_out[7] |=>
      data_rdata == {5'h00, $past(port_config_field)})
      else $error("indirect read wrong");

   chk_warm_latch: assert property (
      @(posedge clock) disable iff (1'b0)
      rst && !reset_is_por |=>
      st.latch == ($past(st.latch) & 6'h20))
      else $error("latch wrong after warm reset");

   chk_cfg_reset: assert property (
      @(posedge clock) disable iff (1'b0)
      rst |=> port_config_field == 3'h0 ##1 1'b1)
      else $error("config field not cleared");

   chk_dir_unimpl: assert property (
      data_req.rd && data_req.addr == 7'h05 &&
      status_out[6:5] == 2'b01 |=> data_rdata[7:6] == 2'b00)
      else $error("unimplemented bits not zero");

   chk_pin_drive: assert property (
      pin_oe[3:0] != 4'h0 |-> (pin_out[3:0] & pin_oe[3:0]) ==
      (st.latch[3:0] & pin_oe[3:0]))
      else $error("driven pin not latch value");

   chk_latch_drive: assert property (
      data_req.wr && data_req.addr == 7'h05 &&
      status_out[6:5] == 2'b00 |=>
      pin_out[3:0] == 4'($past(data_req.wdata)))
      else $error("latch write not on pins");

endmodule // bmm_top

/* test/bmm_core_model.sv */
// Core side model issuing data accesses
`timescale 1ns/1ps
module bmm_core_model import bmm_pkg::*; (
   input  wire logic    clock,
   output bmm_data_req_s data_req
);
   initial data_req = '0;
   task automatic acc(input logic w, input logic [6:0] a,
                      input logic [7:0] d);
      data_req = '{!w, w, a, d};
      @(posedge clock);
      // Released bus shows inverted leftovers
      #2 data_req = '{1'b0, 1'b0, ~a, ~d};
   endtask
endmodule // bmm_core_model

/* test/bmm_top_test.sv */
// Self-checking bench for the banked memory map block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: %h not %h", $time, a, e); end end
module bmm_top_test import bmm_pkg::*;;
   logic          clock = 1'b0;
   logic          rst, reset_is_por;
   logic          pc_inc = 1'b0, pc_load = 1'b0, irq_accept = 1'b0;
   logic [12:0]   pc_load_value = 13'h0000, prog_counter;
   logic [10:0]   fetch_addr;
   logic [7:0]    data_rdata, status_out;
   logic [5:0]    pin_in = 6'h15, pin_out, pin_oe;
   logic [2:0]    port_config_field;
   bmm_data_req_s data_req;
   int            error_cnt = 0, checks = 0, cycles = 0;

   always #12.5 clock = ~clock;

   bmm_top u_bmm_top (.clock, .rst, .reset_is_por, .pc_inc, .pc_load,
      .pc_load_value, .irq_accept, .prog_counter, .fetch_addr, .data_req,
      .data_rdata, .status_out, .pin_in, .pin_out, .pin_oe,
      .port_config_field);
   bmm_core_model u_bmm_core_model (.clock, .data_req);

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_bmm_core_model.acc(1'b1, a, d);
      @(posedge clock);
      #2;
   endtask
   // Read data stands from the cycle after the read edge, RAM read data in that cycle only
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      u_bmm_core_model.acc(1'b0, a, 8'h00);
      `CHK(data_rdata, e)
      @(posedge clock);
      #2;
   endtask
   task automatic do_reset(input logic por);
      rst = 1'b1;
      reset_is_por = por;
      repeat (3) @(posedge clock);
      #2 rst = 1'b0;
   endtask

   task automatic t_reset();
      `CHK(prog_counter, 13'h0000)
      `CHK(pin_oe, 6'h00)
      rd(7'h05, 8'h15);
      wr(7'h03, 8'h20);
      `CHK(status_out, 8'h20)
      rd(7'h03, 8'h20);
      rd(7'h05, 8'h3f);
      rd(7'h1f, 8'h00);
   endtask
   task automatic t_pc();
      pc_load_value = 13'h1ffe;
      pc_load = 1'b1;
      @(posedge clock);
      #2 pc_load = 1'b0;
      `CHK(prog_counter, 13'h1ffe)
      `CHK(fetch_addr, 11'h7fe)
      pc_inc = 1'b1;
      u_bmm_core_model.acc(1'b1, 7'h04, 8'h9f);
      `CHK(fetch_addr, 11'h7ff)
      irq_accept = 1'b1;
      pc_load = 1'b1;
      @(posedge clock);
      #2 {irq_accept, pc_load, pc_inc} = 3'h0;
      `CHK(prog_counter, 13'h0004)
   endtask
   task automatic t_cfg();
      for (int c = 4; c < 8; c++) begin
         wr(7'h1f, 8'(c));
         `CHK(port_config_field, 3'(c))
      end
      wr(7'h1f, 8'hff);
      rd(7'h1f, 8'h07);
      rd(7'h00, 8'h07);
   endtask
   task automatic t_port();
      wr(7'h05, 8'h00);
      `CHK(pin_oe, 6'h3f)
      wr(7'h03, 8'h00);
      wr(7'h05, 8'hff);
      `CHK(pin_oe, 6'h2f)
      `CHK(pin_out, 6'h2f)
   endtask
   task automatic t_latch(input logic por, input logic [5:0] e);
      do_reset(por);
      `CHK(pin_oe, 6'h00)
      wr(7'h03, 8'h20);
      wr(7'h05, 8'h00);
      wr(7'h03, 8'h00);
      `CHK(pin_out, e)
   endtask
   task automatic t_ram();
      wr(7'h20, 8'h5a);
      wr(7'h03, 8'h20);
      wr(7'h20, 8'ha5);
      wr(7'h03, 8'h00);
      wr(7'h04, 8'h20);
      rd(7'h00, 8'h5a);
      rd(7'h10, 8'h00);
      wr(7'h03, 8'h60);
      rd(7'h20, 8'ha5);
   endtask

   task automatic report_and_stop();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   initial begin
      do_reset(1'b1);
      t_reset();
      t_pc();
      t_cfg();
      t_port();
      t_latch(1'b0, 6'h20);
      t_latch(1'b1, 6'h00);
      t_ram();
      report_and_stop();
   end
endmodule // bmm_top_test
